// ### verilog/see_pkg.sv
package see_pkg;

   // =====================================================================
   // Array organisation
   // =====================================================================
   localparam int unsigned MEM_BYTES  = 4096;
   localparam int unsigned ADDR_W     = 12;
   localparam int unsigned PAGE_BYTES = 32;
   localparam int unsigned COL_W      = 5;
   localparam int unsigned ROW_W      = 7;
   localparam int unsigned BYTE_W     = 8;

   // Word-address byte layout: low nibble of the first byte is used
   localparam int unsigned HI_USED_W  = 4;

   // =====================================================================
   // Device address word
   // =====================================================================
   // Device-type code: value is arbitrary
   localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
   localparam logic       DIR_READ      = 1'b1;

   // =====================================================================
   // Serial framing
   // =====================================================================
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [2:0] TX_LAST_BIT   = 3'h7;

   // =====================================================================
   // Write buffering
   // =====================================================================
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned FIFO_W     = ADDR_W + BYTE_W;

   // =====================================================================
   // Timing
   // =====================================================================
   localparam int unsigned MCLK_HZ       = 25_000_000;
   localparam int unsigned PROG_TIME_MS  = 3;
   // Longest time: rounds down
   localparam int unsigned PROG_CYCLES   = PROG_TIME_MS * (MCLK_HZ / 1000);
   localparam int unsigned PROG_CNT_W    = 20;

   // =====================================================================
   // State encodings
   // =====================================================================
   typedef enum logic [2:0]
   {
      S_IDLE = 3'b000,
      S_RX   = 3'b001,
      S_ACK  = 3'b010,
      S_TX   = 3'b011,
      S_MACK = 3'b100
   } see_link_e;

   typedef enum logic [1:0]
   {
      K_DEV  = 2'b00,
      K_HI   = 2'b01,
      K_LO   = 2'b10,
      K_DATA = 2'b11
   } see_kind_e;

   typedef enum logic [1:0]
   {
      P_IDLE   = 2'b00,
      P_DRAIN  = 2'b01,
      P_COMMIT = 2'b10,
      P_WAIT   = 2'b11
   } see_prog_e;

endpackage : see_pkg

// ### verilog/see_sync.sv
`timescale 1ns/1ns

// =====================================================================
// Two-stage synchroniser with a third stage for edge finding
// =====================================================================
module see_sync
#(
   parameter int unsigned W   = 1,
   parameter logic [W-1:0] RST = '0
)
(
   input  wire logic         i_mclk,   // System clock
   input  wire logic         i_reset,  // Synchronous reset, high
   input  wire logic [W-1:0] i_async,  // Pins from outside the domain
   output logic      [W-1:0] o_level,  // Synchronised level
   output logic      [W-1:0] o_prev    // Level one cycle earlier
);

   logic [W-1:0] meta;
   logic [W-1:0] stab;
   logic [W-1:0] late;

   genvar g;
   // Per bit: first stage feeds only the second
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         always_ff @(posedge i_mclk)
         begin
            if (i_reset)
            begin
               meta[g] <= RST[g];
               stab[g] <= RST[g];
               late[g] <= RST[g];
            end
            else
            begin
               meta[g] <= i_async[g];
               stab[g] <= meta[g];
               late[g] <= stab[g];
            end
         end
      end
   endgenerate

   assign o_level = stab;
   assign o_prev  = late;

endmodule : see_sync

// ### verilog/see_fifo.sv
`timescale 1ns/1ns

// =====================================================================
// Small synchronous FIFO, valid/ready on both sides
// =====================================================================
module see_fifo
#(
   parameter int unsigned W = 8,
   parameter int unsigned D = 8
)
(
   input  wire logic         i_mclk,     // System clock
   input  wire logic         i_reset,    // Synchronous reset, high
   input  wire logic         i_in_valid, // Fill side offers a word
   output logic              o_in_ready, // Room for a word
   input  wire logic [W-1:0] i_in_data,  // Word to store
   output logic              o_out_valid,// Oldest word present
   input  wire logic         i_out_ready,// Drain side takes it
   output logic      [W-1:0] o_out_data  // Oldest word
);

   localparam int unsigned AW = $clog2(D);

   logic [W-1:0] store [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic          push;
   logic          pop;

   // Handshakes
   assign o_in_ready  = (count != (AW+1)'(D));
   assign o_out_valid = (count != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = store[rd_ptr];

   // Storage
   always_ff @(posedge i_mclk)
   begin
      if (push)
         store[wr_ptr] <= i_in_data;
   end

   // Pointers and fill level
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end

endmodule : see_fifo

// ### verilog/see_slave.sv
`timescale 1ns/1ns

module see_slave
#(
   parameter int unsigned P_PROG_CYCLES = see_pkg::PROG_CYCLES
)
(
   input  wire logic       i_mclk,      // 25 MHz system clock
   input  wire logic       i_reset,     // Synchronous reset, high
   input  wire logic       i_scl,       // Serial clock pin
   input  wire logic       i_sda,       // Serial data pin level
   output logic            o_sda,       // Serial data drive value
   output logic            o_sda_oe,    // High while pulling SDA low
   input  wire logic [2:0] i_strap_address_inputs, // Strap pins
   input  wire logic       i_wp,        // Write protect pin
   output logic            o_standby,   // Low-power standby
   output logic            o_prog_busy  // Programming cycle running
);

   // =====================================================================
   // Pin synchronisers
   // =====================================================================
   logic [1:0] bus_level;
   logic [1:0] bus_prev;
   logic [3:0] cfg_level;

   see_sync #(.W(2), .RST(2'h3)) u_bus_sync
   (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_async ({i_scl, i_sda}),
      .o_level (bus_level),
      .o_prev  (bus_prev)
   );

   see_sync #(.W(4), .RST(4'h0)) u_cfg_sync
   (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_async ({i_wp, i_strap_address_inputs}),
      .o_level (cfg_level),
      .o_prev  ()
   );

   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;
   logic       wp;
   logic [2:0] straps;

   assign scl      = bus_level[1];
   assign sda      = bus_level[0];
   assign scl_rise = scl && !bus_prev[1];
   assign scl_fall = !scl && bus_prev[1];
   assign wp       = cfg_level[3];
   assign straps   = cfg_level[2:0];

   // Data edges under a steady high clock are frame markers
   assign start_seen = scl && bus_prev[1] && !sda && bus_prev[0];
   assign stop_seen  = scl && bus_prev[1] && sda && !bus_prev[0];

   // =====================================================================
   // Storage and shared state
   // =====================================================================
   logic [see_pkg::BYTE_W-1:0]  mem [see_pkg::MEM_BYTES];
   logic [see_pkg::BYTE_W-1:0]  page_data [see_pkg::PAGE_BYTES];
   logic [see_pkg::PAGE_BYTES-1:0] page_valid;
   logic [see_pkg::ROW_W-1:0]   page_row;

   see_pkg::see_link_e st;
   see_pkg::see_kind_e kind;
   see_pkg::see_prog_e pst;

   logic [3:0]                  bitcnt;
   logic [2:0]                  tx_cnt;
   logic [see_pkg::BYTE_W-1:0]  rx_sh;
   logic [see_pkg::BYTE_W-1:0]  tx_sh;
   logic                        is_read;
   logic                        wrote;
   logic                        mack;
   logic [see_pkg::ADDR_W-1:0]  addr_cnt;
   logic [see_pkg::COL_W-1:0]   commit_idx;
   logic [see_pkg::PROG_CNT_W-1:0] prog_cnt;

   logic                        fifo_in_ready;
   logic                        fifo_out_valid;
   logic                        fifo_out_ready;
   logic [see_pkg::FIFO_W-1:0]  fifo_out_data;

   // =====================================================================
   // Byte-level strobes
   // =====================================================================
   logic busy;
   logic byte_done;
   logic dev_match;
   logic push_data;
   logic load_tx;
   logic first_tx;

   // While programming, the link logic is held and sees nothing
   assign busy      = (pst != see_pkg::P_IDLE);
   assign byte_done = scl_fall && (st == see_pkg::S_RX)
                      && (bitcnt == see_pkg::BITS_PER_WORD);
   assign dev_match = (rx_sh[7:4] == see_pkg::DEV_TYPE_CODE)
                      && (rx_sh[3:1] == straps);
   // Data words queue only while the buffer has room
   assign push_data = byte_done && (kind == see_pkg::K_DATA) && fifo_in_ready;
   assign first_tx  = scl_fall && (st == see_pkg::S_ACK) && is_read;
   assign load_tx   = first_tx
                      || (scl_fall && (st == see_pkg::S_MACK) && mack);

   // =====================================================================
   // Link state machine
   // =====================================================================
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st      <= see_pkg::S_IDLE;
         kind    <= see_pkg::K_DEV;
         bitcnt  <= '0;
         rx_sh   <= '0;
         tx_sh   <= '0;
         tx_cnt  <= '0;
         is_read <= 1'b0;
         wrote   <= 1'b0;
         mack    <= 1'b0;
      end
      else if (busy)
      begin
         st    <= see_pkg::S_IDLE;
         kind  <= see_pkg::K_DEV;
         wrote <= 1'b0;
      end
      else if (start_seen)
      begin
         // A start, repeated or not, restarts at the header unless programming holds the link
         st     <= see_pkg::S_RX;
         kind   <= see_pkg::K_DEV;
         bitcnt <= '0;
      end
      else if (stop_seen)
      begin
         st    <= see_pkg::S_IDLE;
         kind  <= see_pkg::K_DEV;
         wrote <= 1'b0;
      end
      else
      begin
         case (st)
            see_pkg::S_RX:
            begin
               if (scl_rise && (bitcnt != see_pkg::BITS_PER_WORD))
               begin
                  rx_sh  <= {rx_sh[6:0], sda};
                  bitcnt <= bitcnt + 1'b1;
               end
               else if (byte_done)
               begin
                  bitcnt <= '0;
                  case (kind)
                     see_pkg::K_DEV:
                     begin
                        if (dev_match)
                        begin
                           st      <= see_pkg::S_ACK;
                           is_read <= (rx_sh[0] == see_pkg::DIR_READ);
                           kind    <= see_pkg::K_HI;
                        end
                        else
                           st <= see_pkg::S_IDLE;
                     end
                     see_pkg::K_HI:
                     begin
                        st   <= see_pkg::S_ACK;
                        kind <= see_pkg::K_LO;
                     end
                     see_pkg::K_LO:
                     begin
                        st   <= see_pkg::S_ACK;
                        kind <= see_pkg::K_DATA;
                     end
                     default:
                     begin
                        // Full buffer answers with a missing acknowledge
                        if (push_data)
                        begin
                           st    <= see_pkg::S_ACK;
                           wrote <= 1'b1;
                        end
                        else
                           st <= see_pkg::S_IDLE;
                     end
                  endcase
               end
            end
            see_pkg::S_ACK:
            begin
               if (scl_fall)
                  st <= is_read ? see_pkg::S_TX : see_pkg::S_RX;
            end
            see_pkg::S_TX:
            begin
               if (scl_fall)
               begin
                  if (tx_cnt == see_pkg::TX_LAST_BIT)
                     st <= see_pkg::S_MACK;
                  else
                  begin
                     tx_sh  <= {tx_sh[6:0], 1'b0};
                     tx_cnt <= tx_cnt + 1'b1;
                  end
               end
            end
            see_pkg::S_MACK:
            begin
               if (scl_rise)
                  mack <= !sda;
               else if (scl_fall && !mack)
                  st <= see_pkg::S_IDLE;
               else if (scl_fall)
                  st <= see_pkg::S_TX;
            end
            default:
               st <= see_pkg::S_IDLE;
         endcase
         // Next outgoing word comes from the counter
         if (load_tx)
         begin
            tx_sh  <= mem[addr_cnt];
            tx_cnt <= '0;
         end
      end
   end

   // =====================================================================
   // Data line drive
   // =====================================================================
   // Set only on the cycle after a clock fall; start, stop, reset and busy clear it at once, even under SCL high
   always_ff @(posedge i_mclk)
   begin
      if (i_reset || busy || start_seen || stop_seen)
         o_sda_oe <= 1'b0;
      else if (byte_done)
         o_sda_oe <= (kind == see_pkg::K_DEV) ? dev_match
                   : (kind == see_pkg::K_DATA) ? push_data
                   : 1'b1;
      else if (load_tx)
         o_sda_oe <= !mem[addr_cnt][7];
      else if (scl_fall && (st == see_pkg::S_TX))
         o_sda_oe <= (tx_cnt == see_pkg::TX_LAST_BIT) ? 1'b0 : !tx_sh[6];
      else if (scl_fall && (st == see_pkg::S_ACK))
         o_sda_oe <= 1'b0;
   end

   // Open drain: the drive value is always low
   always_ff @(posedge i_mclk)
   begin
      o_sda <= 1'b0;
   end

   // =====================================================================
   // Address counter
   // =====================================================================
   // Kept across operations; only reset clears it
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
         addr_cnt <= '0;
      else if (!busy && byte_done && (kind == see_pkg::K_HI))
         addr_cnt[11:8] <= rx_sh[see_pkg::HI_USED_W-1:0];
      else if (!busy && byte_done && (kind == see_pkg::K_LO))
         addr_cnt[7:0] <= rx_sh;
      else if (!busy && push_data)
         addr_cnt[see_pkg::COL_W-1:0] <= addr_cnt[see_pkg::COL_W-1:0] + 1'b1;
      else if (!busy && load_tx)
         addr_cnt <= addr_cnt + 1'b1;
   end

   // =====================================================================
   // Write data buffering
   // =====================================================================
   see_fifo #(.W(see_pkg::FIFO_W), .D(see_pkg::FIFO_DEPTH)) u_fifo
   (
      .i_mclk      (i_mclk),
      .i_reset     (i_reset),
      .i_in_valid  (push_data && !busy),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({addr_cnt, rx_sh}),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready),
      .o_out_data  (fifo_out_data)
   );

   // Page buffer only fills before the commit starts
   assign fifo_out_ready = (pst == see_pkg::P_IDLE) || (pst == see_pkg::P_DRAIN);

   // Page buffer collects words; later ones overwrite by column
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         page_valid <= '0;
         page_row   <= '0;
      end
      else if (fifo_out_valid && fifo_out_ready)
      begin
         page_row <= fifo_out_data[see_pkg::FIFO_W-1 -: see_pkg::ROW_W];
         page_data[fifo_out_data[see_pkg::BYTE_W +: see_pkg::COL_W]]
            <= fifo_out_data[see_pkg::BYTE_W-1:0];
         page_valid[fifo_out_data[see_pkg::BYTE_W +: see_pkg::COL_W]] <= 1'b1;
      end
      else if ((pst == see_pkg::P_WAIT) || ((pst == see_pkg::P_IDLE) && wp))
         page_valid <= '0;
   end

   // =====================================================================
   // Programming cycle
   // =====================================================================
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         pst        <= see_pkg::P_IDLE;
         commit_idx <= '0;
         prog_cnt   <= '0;
      end
      else
      begin
         case (pst)
            see_pkg::P_IDLE:
            begin
               // Timer starts at the stop closing a write
               if (stop_seen && wrote && !wp)
                  pst <= see_pkg::P_DRAIN;
               commit_idx <= '0;
               prog_cnt   <= '0;
            end
            see_pkg::P_DRAIN:
            begin
               prog_cnt <= prog_cnt + 1'b1;
               if (!fifo_out_valid)
                  pst <= see_pkg::P_COMMIT;
            end
            see_pkg::P_COMMIT:
            begin
               prog_cnt   <= prog_cnt + 1'b1;
               commit_idx <= commit_idx + 1'b1;
               if (commit_idx == see_pkg::COL_W'(see_pkg::PAGE_BYTES - 1))
                  pst <= see_pkg::P_WAIT;
            end
            default:
            begin
               // Whole cycle from the stop lasts the programmed time
               prog_cnt <= prog_cnt + 1'b1;
               if (prog_cnt >= see_pkg::PROG_CNT_W'(P_PROG_CYCLES - 1))
                  pst <= see_pkg::P_IDLE;
            end
         endcase
      end
   end

   // Array write, one page column per cycle
   always_ff @(posedge i_mclk)
   begin
      if ((pst == see_pkg::P_COMMIT) && page_valid[commit_idx] && !wp)
         mem[{page_row, commit_idx}] <= page_data[commit_idx];
   end

   // =====================================================================
   // Status outputs
   // =====================================================================
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         o_standby   <= 1'b1;
         o_prog_busy <= 1'b0;
      end
      else
      begin
         o_standby   <= (st == see_pkg::S_IDLE) && !busy && !fifo_out_valid;
         o_prog_busy <= busy;
      end
   end

endmodule : see_slave

// ### verification/see_slave_monitor.sv
`timescale 1ns/1ns

// ==========
// Slave port checker
// ==========
module see_slave_monitor
#(
   parameter int unsigned P_PROG_CYCLES = see_pkg::PROG_CYCLES
)
(
   input  wire logic       i_mclk,      // System clock
   input  wire logic       i_reset,     // Synchronous reset
   input  wire logic       i_scl,       // Bus clock pin
   input  wire logic       i_sda,       // Data wire
   input  wire logic       o_sda,       // Drive value
   input  wire logic       o_sda_oe,    // Drive enable
   input  wire logic [2:0] i_strap_address_inputs, // Straps
   input  wire logic       i_wp,        // Write protect
   input  wire logic       o_standby,   // Standby
   input  wire logic       o_prog_busy  // Programming
);
   logic [19:0] busy_len;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   // Busy length; cleared between cycles so each one is timed alone
   always_ff @(posedge i_mclk)
      busy_len <= (i_reset || !o_prog_busy) ? 20'h00000 : busy_len + 20'h00001;

   a_reset_quiet: assert property (disable iff (1'b0) i_reset |=> !o_sda_oe && !o_prog_busy)
      else $error("outputs active after reset");
   a_busy_no_ack: assert property (o_prog_busy |-> !o_sda_oe)
      else $error("drive while programming");
   a_busy_not_standby: assert property (o_prog_busy |-> !o_standby)
      else $error("standby while programming");
   a_standby_released: assert property (o_standby |-> !o_sda_oe)
      else $error("drive in standby");
   a_standby_after_prog: assert property ($fell(o_prog_busy) |-> ##[0:4] o_standby)
      else $error("no standby after programming");
   a_prog_length: assert property ($fell(o_prog_busy) |->
         busy_len >= P_PROG_CYCLES - 2 && busy_len <= P_PROG_CYCLES)
      else $error("programming length wrong");
   // Late enough after the rise that the slave's own edge delay cannot fake a change
   a_data_stable_high: assert property ($rose(i_scl) |-> ##2 $stable(o_sda_oe)[*2])
      else $error("data changed while clock high");
   a_protect_no_prog: assert property ($rose(o_prog_busy) |-> !$past(i_wp, 8))
      else $error("programming while protected");
endmodule : see_slave_monitor

// ### verification/see_bus_master.sv
`timescale 1ns/1ns

// ==========
// Two-wire master model, 320 ns bit time
// ==========
module see_bus_master
(
   input  wire logic i_mclk,        // Bench clock
   input  wire logic i_sda,         // Resolved data wire
   output logic      o_scl = 1'b1,  // Bus clock, still when idle
   output logic      o_oe = 1'b0    // High while pulling data low
);
   // Quarter bit: two system clocks, then move the pins
   task automatic q(input logic c, input logic d);
      repeat (2) @(posedge i_mclk);
      o_scl <= c;
      o_oe <= d;
   endtask : q

   // Data moves only in the low half; sample mid high
   task automatic bit_io(input logic b, output logic s);
      q(1'b0, o_oe);
      q(1'b0, !b);
      q(1'b1, !b);
      q(1'b1, !b);
      s = i_sda;
   endtask : bit_io

   task automatic start();
      if (!i_sda)
      begin
         q(1'b0, o_oe);
         q(1'b0, 1'b0);
      end
      q(1'b1, 1'b0);
      q(1'b1, 1'b1);
   endtask : start

   // Clock until the slave lets the data line go, at most nine times, then start
   task automatic recover();
      for (int i = 0; i < 9; i++)
      begin
         q(1'b0, 1'b0);
         q(1'b0, 1'b0);
         q(1'b1, 1'b0);
         q(1'b1, 1'b0);
         if (i_sda)
            break;
      end
      start();
   endtask : recover

   task automatic stop();
      q(1'b0, o_oe);
      q(1'b0, 1'b1);
      q(1'b1, 1'b1);
      q(1'b1, 1'b0);
      q(1'b1, 1'b0);
   endtask : stop

   task automatic wr(input logic [7:0] d, output logic k);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], s);
      bit_io(1'b1, s);
      k = !s;
   endtask : wr

   task automatic rd(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!mack, s);
   endtask : rd
endmodule : see_bus_master

// ### verification/test_see_slave.sv
`timescale 1ns/1ns

// ==========
// Bench for the serial memory slave
// ==========
module test_see_slave;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       wp = 1'b0;
   logic [2:0] strap = 3'h5;
   logic       scl;
   logic       m_oe;
   logic       oe;
   logic       sd;
   logic       busy;
   wire        sda;
   int         bad_count = 0;
   int         checked = 0;

   // Open-drain wire with pull-up
   assign sda = !m_oe && !(oe && !sd);

   see_slave #(.P_PROG_CYCLES(200)) dut
   (
      .i_mclk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda), .o_sda(sd), .o_sda_oe(oe),
      .i_strap_address_inputs(strap), .i_wp(wp), .o_standby(), .o_prog_busy(busy)
   );

   see_bus_master m (.i_mclk(clk), .i_sda(sda), .o_scl(scl), .o_oe(m_oe));

   initial
   begin
      forever #20 clk = !clk;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask : chk

   task automatic hdr(input logic rw, input logic [2:0] s, output logic k);
      m.start();
      m.wr({see_pkg::DEV_TYPE_CODE, s, rw}, k);
   endtask : hdr

   // Upper nibble of the high byte is junk on purpose
   task automatic setaddr(input logic [11:0] a);
      logic k;
      hdr(1'b0, strap, k);
      chk("header ack", 8'h01, {7'h00, k});
      m.wr({4'hC, a[11:8]}, k);
      m.wr(a[7:0], k);
      chk("address ack", 8'h01, {7'h00, k});
   endtask : setaddr

   task automatic wpage(input logic [11:0] a, input logic [7:0] d0, input logic [7:0] d1,
                        input logic prot);
      logic k;
      setaddr(a);
      m.wr(d0, k);
      m.wr(d1, k);
      chk("data ack", 8'h01, {7'h00, k});
      m.stop();
      hdr(1'b0, strap, k);
      chk("poll ack", {7'h00, prot}, {7'h00, k});
      m.stop();
      for (int n = 0; n < 400 && busy !== 1'b0; n++)
         @(posedge clk);
      chk("busy end", 8'h00, {7'h00, busy});
   endtask : wpage

   task automatic t_mismatch();
      logic k;
      hdr(1'b1, strap ^ 3'h1, k);
      chk("foreign strap", 8'h00, {7'h00, k});
      m.stop();
      // Own address must still be answered after a foreign one
      hdr(1'b0, strap, k);
      chk("own strap", 8'h01, {7'h00, k});
      m.stop();
      m.start();
      m.wr({see_pkg::DEV_TYPE_CODE ^ 4'h1, strap, 1'b1}, k);
      chk("foreign type", 8'h00, {7'h00, k});
      m.stop();
   endtask : t_mismatch

   // Second byte of the first page write lands on the wrapped column
   task automatic t_write();
      wpage(12'hFFF, 8'h77, 8'h88, 1'b0);
      wpage(12'h000, 8'h99, 8'hAA, 1'b0);
   endtask : t_write

   task automatic t_protect();
      wp <= 1'b1;
      wpage(12'h000, 8'h11, 8'h22, 1'b1);
      wp <= 1'b0;
   endtask : t_protect

   task automatic t_reads();
      logic [7:0] d;
      logic       k;
      setaddr(12'hFE0);
      hdr(1'b1, strap, k);
      m.rd(1'b0, d);
      chk("page wrap", 8'h88, d);
      m.stop();
      setaddr(12'hFFF);
      hdr(1'b1, strap, k);
      m.rd(1'b1, d);
      chk("read", 8'h77, d);
      m.rd(1'b0, d);
      chk("array wrap", 8'h99, d);
      m.stop();
      hdr(1'b1, strap, k);
      m.rd(1'b0, d);
      chk("current", 8'hAA, d);
      m.stop();
      // Abandon a read mid-byte, clock the slave off the wire, then start again
      setaddr(12'hFFF);
      hdr(1'b1, strap, k);
      m.recover();
      m.wr({see_pkg::DEV_TYPE_CODE, strap, 1'b0}, k);
      chk("ack after recovery", 8'h01, {7'h00, k});
      m.stop();
   endtask : t_reads

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_mismatch();
      t_write();
      t_protect();
      t_reads();
      close_out();
   end

   // Hang guard, far beyond the few thousand cycles the run needs
   initial
   begin
      #1_000_000;
      bad_count++;
      close_out();
   end
endmodule : test_see_slave

bind see_slave see_slave_monitor #(.P_PROG_CYCLES(P_PROG_CYCLES)) u_mon
(
   .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
   .o_sda_oe(o_sda_oe), .i_strap_address_inputs(i_strap_address_inputs), .i_wp(i_wp),
   .o_standby(o_standby), .o_prog_busy(o_prog_busy)
);
